// *** hw/scope_pattern_trigger_unit.v ***
// Purpose: Pattern trigger qualifier with event count and auto-trigger
// Assumes: APB slave, zero wait states; comparator inputs are asynchronous
// Notes: Software arms each acquisition through the control register
//
// Functional notes
// - Auto-trigger on/off, defaults on
// - Auto on: force completion after 50 ms
// - Forced completion sets auto-triggered status
// - Auto off: wait forever, show waiting
// - Condition selector, default pattern entry
// - Entry: trigger on becoming true, counted
// - Exit: trigger on becoming false, counted
// - Longer-than: true at least duration, then false
// - Shorter-than: false before duration elapses
// - Durations 20 ns to 160 ms, 10 ns
// - Range: between minimum and maximum
// - Count one: first event meeting both
// - Later counted events need no duration
// - Trigger after programmed number of events
// - Count 1 to 32000, default 1
// - Terms high, low, don't-care; default don't-care
// - All don't-care never fires
// - Immediate mode triggers without waiting
//
// Added by the designer: the APB register port and the register offsets.
`include "scope_trigger_defines.vh"

module scope_pattern_trigger_unit #(
   parameter [22:0] AUTO_TIMEOUT_CYCLES = `AUTO_TIMEOUT_CYCLES
) (
   input wire clock,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [1:0] chAbove,
   output reg trigger,
   output reg autoTrigger,
   output reg acquireDone,
   output reg waitingForTrigger
);

localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_WAIT = 3'b010;
localparam [2:0] ST_DONE = 3'b100;

////////////////////////////////////////////////////////////////////////////////
// Configuration and state

reg immediateMode;
reg autoTrig;
reg [3:0] terms;
reg [2:0] whenSel;
reg [14:0] countTarget;
reg [23:0] durMin;
reg [23:0] durMax;
reg [2:0] state;
reg [14:0] eventsSeen;
reg [22:0] timeoutCount;
reg trigFlag;
reg autoFlag;
reg patPrev;
reg [1:0] syncA;
reg [1:0] syncB;
wire [1:0] termOk;
wire [1:0] termUsed;
wire patTrue;
wire patRise;
wire patFall;
wire [23:0] elapsed;
reg durOk;
reg countEvent;
wire lastEvent;
wire [15:0] eventsNext;
wire apbWrite;
wire apbSetup;
reg addrHit;
reg [31:0] readMux;
wire armReq;
reg [14:0] next_count;
reg [23:0] next_min;
reg [23:0] next_max;

////////////////////////////////////////////////////////////////////////////////
// Comparator inputs and pattern match

genvar ch;
generate
   for (ch = 0; ch < 2; ch = ch + 1) begin : gChannel
      always @(posedge clock) begin
         if (sys_rst) begin
            syncA[ch] <= 1'b0;
            syncB[ch] <= 1'b0;
         end else begin
            syncA[ch] <= chAbove[ch];
            syncB[ch] <= syncA[ch];
         end
      end
      // Don't-care terms pass, but do not count as participating
      assign termUsed[ch] = (terms[2*ch+1:2*ch] != `TERM_X);
      assign termOk[ch] = (terms[2*ch+1:2*ch] == `TERM_H) ? syncB[ch] :
                          (terms[2*ch+1:2*ch] == `TERM_L) ? ~syncB[ch] :
                          1'b1;
   end
endgenerate

// A pattern with no participating input is never true
assign patTrue = (&termOk) & (|termUsed);

always @(posedge clock) begin
   if (sys_rst) begin
      patPrev <= 1'b0;
   end else begin
      patPrev <= patTrue;
   end
end

assign patRise = patTrue & ~patPrev;
assign patFall = ~patTrue & patPrev;

duration_timer uTimer (
   .clock(clock),
   .sys_rst(sys_rst),
   .restart(patRise),
   .elapsed(elapsed)
);

////////////////////////////////////////////////////////////////////////////////
// Event qualification

// Elapsed at the falling edge is the true time of the finished pulse
always @* begin
   case (whenSel)
      `WHEN_LONGER: durOk = (elapsed >= durMin);
      `WHEN_SHORTER: durOk = (elapsed < durMin);
      `WHEN_RANGE: durOk = (elapsed > durMin) && (elapsed < durMax);
      default: durOk = 1'b1;
   endcase
end

always @* begin
   case (whenSel)
      `WHEN_ENTERED: countEvent = patRise;
      `WHEN_EXITED: countEvent = patFall;
      // Only the first counted pulse must pass the duration test
      default: countEvent = patFall & ((eventsSeen != 15'h0000) | durOk);
   endcase
end

assign eventsNext = {1'b0, eventsSeen} + 16'h0001;
assign lastEvent = countEvent & (eventsNext >= {1'b0, countTarget});

////////////////////////////////////////////////////////////////////////////////
// Acquisition sequencer

always @(posedge clock) begin
   if (sys_rst) begin
      state <= ST_IDLE;
      eventsSeen <= 15'h0000;
      timeoutCount <= 23'h000000;
      trigFlag <= 1'b0;
      autoFlag <= 1'b0;
      trigger <= 1'b0;
      autoTrigger <= 1'b0;
      acquireDone <= 1'b0;
      waitingForTrigger <= 1'b0;
   end else begin
      trigger <= 1'b0;
      autoTrigger <= 1'b0;
      acquireDone <= 1'b0;
      case (state)
         ST_IDLE, ST_DONE: begin
            waitingForTrigger <= 1'b0;
            if (armReq) begin
               state <= ST_WAIT;
               eventsSeen <= 15'h0000;
               timeoutCount <= 23'h000000;
               trigFlag <= 1'b0;
               autoFlag <= 1'b0;
            end
         end
         ST_WAIT: begin
            waitingForTrigger <= ~autoTrig & ~immediateMode;
            if (immediateMode) begin
               state <= ST_DONE;
               trigFlag <= 1'b1;
               trigger <= 1'b1;
               acquireDone <= 1'b1;
               waitingForTrigger <= 1'b0;
            end else if (lastEvent) begin
               // A real trigger wins over a timeout in the same cycle
               state <= ST_DONE;
               trigFlag <= 1'b1;
               trigger <= 1'b1;
               acquireDone <= 1'b1;
               eventsSeen <= eventsNext[14:0];
               waitingForTrigger <= 1'b0;
            end else if (autoTrig && (timeoutCount == AUTO_TIMEOUT_CYCLES - 23'h000001)) begin
               state <= ST_DONE;
               autoFlag <= 1'b1;
               autoTrigger <= 1'b1;
               acquireDone <= 1'b1;
            end else begin
               if (countEvent) begin
                  eventsSeen <= eventsNext[14:0];
               end
               // Turning auto off mid-wait restarts the 50 ms window
               if (autoTrig) begin
                  timeoutCount <= timeoutCount + 23'h000001;
               end else begin
                  timeoutCount <= 23'h000000;
               end
            end
         end
         default: begin
            state <= ST_IDLE;
            waitingForTrigger <= 1'b0;
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////////
// APB slave

assign pready = 1'b1;
assign apbSetup = psel & ~penable;
assign apbWrite = psel & penable & pwrite & addrHit;
assign pslverr = psel & penable & ~addrHit;
assign armReq = apbWrite && (paddr == `OFS_CONTROL) && pwdata[`CTRL_ARM];

always @* begin
   case (paddr)
      `OFS_CONTROL, `OFS_PATTERN, `OFS_WHEN, `OFS_COUNT,
      `OFS_DUR_MIN, `OFS_DUR_MAX, `OFS_STATUS: addrHit = 1'b1;
      default: addrHit = 1'b0;
   endcase
end

// Out-of-range values are clamped rather than refused
always @* begin
   next_count = pwdata[14:0];
   if (pwdata[31:15] != 17'h00000 || pwdata[14:0] > `COUNT_LIMIT) begin
      next_count = `COUNT_LIMIT;
   end else if (pwdata[14:0] == 15'h0000) begin
      next_count = 15'h0001;
   end
   next_min = pwdata[23:0];
   if (pwdata[31:24] != 8'h00 || pwdata[23:0] > `DUR_HIGH_LIMIT) begin
      next_min = `DUR_HIGH_LIMIT;
   end else if (pwdata[23:0] < `DUR_LOW_LIMIT) begin
      next_min = `DUR_LOW_LIMIT;
   end
   next_max = pwdata[23:0];
   if (pwdata[31:24] != 8'h00 || pwdata[23:0] > `DUR_HIGH_LIMIT) begin
      next_max = `DUR_HIGH_LIMIT;
   end else if (pwdata[23:0] < `DUR_LOW_LIMIT) begin
      next_max = `DUR_LOW_LIMIT;
   end
end

always @(posedge clock) begin
   if (sys_rst) begin
      immediateMode <= `IMMEDIATE_RESET;
      autoTrig <= `AUTO_RESET;
      terms <= `PATTERN_RESET;
      whenSel <= `WHEN_RESET;
      countTarget <= `COUNT_RESET;
      durMin <= `DUR_LOW_LIMIT;
      durMax <= `DUR_MAX_RESET;
   end else if (apbWrite) begin
      case (paddr)
         `OFS_CONTROL: begin
            immediateMode <= pwdata[`CTRL_IMMEDIATE];
            autoTrig <= pwdata[`CTRL_AUTO];
         end
         `OFS_PATTERN: terms <= pwdata[3:0];
         `OFS_WHEN: begin
            // Unused codes fall back to entry
            if (pwdata[2:0] > `WHEN_RANGE) begin
               whenSel <= `WHEN_ENTERED;
            end else begin
               whenSel <= pwdata[2:0];
            end
         end
         `OFS_COUNT: countTarget <= next_count;
         `OFS_DUR_MIN: durMin <= next_min;
         `OFS_DUR_MAX: durMax <= next_max;
         default: begin
         end
      endcase
   end
end

always @* begin
   readMux = 32'h00000000;
   case (paddr)
      `OFS_CONTROL: begin
         readMux[`CTRL_IMMEDIATE] = immediateMode;
         readMux[`CTRL_AUTO] = autoTrig;
      end
      `OFS_PATTERN: readMux[3:0] = terms;
      `OFS_WHEN: readMux[2:0] = whenSel;
      `OFS_COUNT: readMux[14:0] = countTarget;
      `OFS_DUR_MIN: readMux[23:0] = durMin;
      `OFS_DUR_MAX: readMux[23:0] = durMax;
      `OFS_STATUS: begin
         readMux[`STAT_WAITING] = waitingForTrigger;
         readMux[`STAT_TRIGGERED] = trigFlag;
         readMux[`STAT_AUTO] = autoFlag;
         readMux[`STAT_ARMED] = (state == ST_WAIT);
         readMux[`STAT_EVENTS_LSB+14:`STAT_EVENTS_LSB] = eventsSeen;
      end
      default: readMux = 32'h00000000;
   endcase
end

// Read data is captured in the setup phase so it comes from a register
always @(posedge clock) begin
   if (sys_rst) begin
      prdata <= 32'h00000000;
   end else if (apbSetup) begin
      prdata <= readMux;
   end
end

endmodule // scope_pattern_trigger_unit

// *** hw/scope_trigger_defines.vh ***
// Purpose: Constants for the scope pattern trigger unit
// Assumes: 125 MHz system clock, 10 ns duration step
// Notes: Register offsets are APB byte addresses
`ifndef SCOPE_TRIGGER_DEFINES_VH
`define SCOPE_TRIGGER_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Timing
`define CLOCK_PERIOD_NS 8
`define TICK_NS 10
`define AUTO_TIMEOUT_MS 50
// 50 ms of 8 ns clocks, sized to the timeout counter
`define AUTO_TIMEOUT_CYCLES 23'h5F5E10
// One clock of true time has already passed at the restart edge
`define RESTART_PHASE 4'h8

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define OFS_CONTROL 8'h00
`define OFS_PATTERN 8'h04
`define OFS_WHEN 8'h08
`define OFS_COUNT 8'h0C
`define OFS_DUR_MIN 8'h10
`define OFS_DUR_MAX 8'h14
`define OFS_STATUS 8'h18

////////////////////////////////////////////////////////////////////////////////
// Control fields
`define CTRL_IMMEDIATE 0
`define CTRL_AUTO 1
`define CTRL_ARM 2

// Status fields
`define STAT_WAITING 0
`define STAT_TRIGGERED 1
`define STAT_AUTO 2
`define STAT_ARMED 3
`define STAT_EVENTS_LSB 16

////////////////////////////////////////////////////////////////////////////////
// Reset values and limits
`define IMMEDIATE_RESET 1'b0
`define AUTO_RESET 1'b1
`define PATTERN_RESET 4'h0
`define WHEN_RESET 3'h0
`define COUNT_RESET 15'h0001
`define COUNT_LIMIT 15'h7D00
`define DUR_LOW_LIMIT 24'h000002
`define DUR_HIGH_LIMIT 24'hF42400
`define DUR_MAX_RESET 24'h000003

////////////////////////////////////////////////////////////////////////////////
// Encodings
`define TERM_X 2'h0
`define TERM_H 2'h1
`define TERM_L 2'h2
`define WHEN_ENTERED 3'h0
`define WHEN_EXITED 3'h1
`define WHEN_LONGER 3'h2
`define WHEN_SHORTER 3'h3
`define WHEN_RANGE 3'h4

`endif

// *** hw/duration_timer.v ***
// Purpose: Measures how long the pattern has been true, in 10 ns ticks
// Assumes: Clock period shorter than one tick
// Notes: Saturates at the top count
`include "scope_trigger_defines.vh"

module duration_timer (
   input wire clock,
   input wire sys_rst,
   input wire restart,
   output reg [23:0] elapsed
);

reg [3:0] phase;
wire [31:0] phaseSum;
wire tick;
wire [31:0] next_phase;

// Fractional step: 8 ns per clock builds 10 ns ticks with no drift
assign phaseSum = {28'h0000000, phase} + `CLOCK_PERIOD_NS;
assign tick = (phaseSum >= `TICK_NS);
assign next_phase = tick ? (phaseSum - `TICK_NS) : phaseSum;

always @(posedge clock) begin
   if (sys_rst) begin
      phase <= 4'h0;
      elapsed <= 24'h000000;
   end else if (restart) begin
      // Pattern was already true one clock before restart, so count it
      phase <= `RESTART_PHASE;
      elapsed <= 24'h000000;
   end else begin
      phase <= next_phase[3:0];
      if (tick && (elapsed != 24'hFFFFFF)) begin
         elapsed <= elapsed + 24'h000001;
      end
   end
end

endmodule // duration_timer

// *** testbench/scope_trigger_assertions.sv ***
// Purpose: Port-level checks for the pattern trigger unit
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to the top module from the bench
module scope_trigger_assertions #(
   parameter [22:0] AUTO_TIMEOUT_CYCLES = 23'h0000C8
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] chAbove,
   input wire logic trigger,
   input wire logic autoTrigger,
   input wire logic acquireDone,
   input wire logic waitingForTrigger
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [23:0] quiet;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Any control write restarts it, which also covers arming and auto on
   always @(posedge clock) begin
      if (sys_rst || (psel && penable && pwrite && paddr == 8'h00)) begin
         quiet <= 24'h000000;
      end else if (quiet != 24'hFFFFFF) begin
         quiet <= quiet + 24'h000001;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   AST_RESET_QUIET: assert property ($fell(sys_rst) |->
      !trigger && !autoTrigger && !acquireDone && !waitingForTrigger)
      else $error("output active after reset");
   AST_DONE_CAUSE: assert property (acquireDone |-> trigger || autoTrigger)
      else $error("completion without cause");
   AST_CAUSE_DONE: assert property (trigger || autoTrigger |-> acquireDone)
      else $error("cause without completion");
   AST_TRIG_PULSE: assert property (trigger |=> !trigger [*2])
      else $error("trigger not a single pulse");
   AST_AUTO_PULSE: assert property (autoTrigger |=> !autoTrigger [*2])
      else $error("auto trigger not a single pulse");
   AST_NOT_BOTH: assert property (!(trigger && autoTrigger))
      else $error("trigger and auto trigger together");
   AST_WAIT_NO_AUTO: assert property (waitingForTrigger |-> !autoTrigger)
      else $error("auto trigger while waiting");
   AST_WAIT_ENDS: assert property (trigger |=> !waitingForTrigger)
      else $error("still waiting after trigger");
   AST_AUTO_LATE: assert property (autoTrigger |->
      quiet >= {1'b0, AUTO_TIMEOUT_CYCLES} - 24'h000002)
      else $error("auto trigger too early");
   AST_ZERO_WAIT: assert property (psel && penable |-> pready)
      else $error("wait state inserted");
   AST_UNMAPPED: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
      else $error("unmapped access not refused");
endmodule // scope_trigger_assertions

// *** testbench/threshold_comparators.sv ***
// Purpose: Channel comparator model driving the pattern inputs
// Assumes: Pulses on channel 0, channel 1 held below its level
// Notes: Comparator outputs are real levels, so low between pulses
module threshold_comparators (
   input wire logic clock,
   output logic [1:0] chAbove
);
   timeunit 1ns;
   timeprecision 1ps;
   initial chAbove = 2'h0;
   task automatic pulse(input int width, input int gap);
      @(posedge clock);
      chAbove[0] <= 1'b1;
      repeat (width) @(posedge clock);
      chAbove[0] <= 1'b0;
      repeat (gap) @(posedge clock);
   endtask
endmodule // threshold_comparators

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the pattern trigger unit
// Assumes: Zero-wait APB, timeout shortened to 200 cycles
// Notes: One clock cycle is 0.8 duration ticks
`include "scope_trigger_defines.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [22:0] TIMEOUT = 23'h0000C8;
   logic clock, sys_rst, psel, penable, pwrite, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, rdata;
   wire [31:0] prdata;
   wire pready, pslverr, trigger, autoTrigger, acquireDone, waitingForTrigger;
   wire [1:0] chAbove;
   int err_total, checks, trigCount, autoCount;
   scope_pattern_trigger_unit #(.AUTO_TIMEOUT_CYCLES(TIMEOUT)) dut (.clock(clock),
      .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chAbove(chAbove), .trigger(trigger), .autoTrigger(autoTrigger),
      .acquireDone(acquireDone), .waitingForTrigger(waitingForTrigger));
   threshold_comparators comp (.clock(clock), .chAbove(chAbove));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      if (trigger === 1'b1) trigCount++;
      if (autoTrigger === 1'b1) autoCount++;
   end
   task automatic give_verdict;
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) begin
         check(0, 1, "no ready");
         give_verdict();
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check(rdata, exp, "register read");
   endtask
   task automatic wait_auto(input int base);
      int n;
      n = 0;
      while (autoCount == base && n < 400) begin
         @(posedge clock);
         n++;
      end
      if (n >= 400) begin
         check(0, 1, "no auto trigger");
         give_verdict();
      end
      check(n > TIMEOUT && n <= TIMEOUT + 2, 1, "timeout length");
   endtask
   // Auto off on every setup so only qualified events end the wait
   task automatic setup(input logic [3:0] pat, input logic [2:0] cond, input logic [14:0] cnt,
         input logic [23:0] dmin, input logic [23:0] dmax);
      apb(1'b1, `OFS_PATTERN, {28'h0000000, pat});
      apb(1'b1, `OFS_WHEN, {29'h00000000, cond});
      apb(1'b1, `OFS_COUNT, {17'h00000, cnt});
      apb(1'b1, `OFS_DUR_MIN, {8'h00, dmin});
      apb(1'b1, `OFS_DUR_MAX, {8'h00, dmax});
      apb(1'b1, `OFS_CONTROL, 32'h00000004);
   endtask
   task automatic pulse_run(input int w[4], input int n, input int fireAt);
      int base;
      base = trigCount;
      for (int i = 0; i < n; i++) begin
         comp.pulse(w[i], 12);
         check(trigCount - base, (i + 1 >= fireAt) ? 1 : 0, "trigger count");
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults;
      rd(`OFS_CONTROL, 32'h00000002);
      rd(`OFS_PATTERN, 32'h00000000);
      rd(`OFS_WHEN, 32'h00000000);
      rd(`OFS_COUNT, 32'h00000001);
      rd(8'h40, 32'h00000000);
      check(rerr, 1, "unmapped access");
   endtask
   task automatic t_auto;
      int base;
      base = trigCount;
      apb(1'b1, `OFS_CONTROL, 32'h00000006);
      wait_auto(autoCount);
      check(trigCount - base, 0, "pattern fired");
      apb(1'b0, `OFS_STATUS, 32'h00000000);
      check(rdata & 32'h00000004, 32'h00000004, "auto status");
   endtask
   task automatic t_wait;
      int base;
      int trigBase;
      base = autoCount;
      trigBase = trigCount;
      apb(1'b1, `OFS_CONTROL, 32'h00000004);
      repeat (10) comp.pulse(6, 24);
      check(waitingForTrigger, 1, "waiting level");
      rd(`OFS_STATUS, 32'h00000009);
      check(autoCount - base, 0, "ended wait");
      check(trigCount - trigBase, 0, "pattern fired");
      apb(1'b1, `OFS_CONTROL, 32'h00000002);
      wait_auto(base);
   endtask
   task automatic t_immediate;
      int base;
      base = trigCount;
      apb(1'b1, `OFS_CONTROL, 32'h00000005);
      repeat (3) @(posedge clock);
      check(trigCount - base, 1, "immediate");
   endtask
   task automatic t_limits;
      apb(1'b1, `OFS_COUNT, 32'h00000000);
      rd(`OFS_COUNT, 32'h00000001);
      apb(1'b1, `OFS_COUNT, 32'h00007D01);
      rd(`OFS_COUNT, 32'h00007D00);
      apb(1'b1, `OFS_DUR_MIN, 32'h00000001);
      rd(`OFS_DUR_MIN, 32'h00000002);
      apb(1'b1, `OFS_DUR_MAX, 32'h00FFFFFF);
      rd(`OFS_DUR_MAX, 32'h00F42400);
      apb(1'b1, `OFS_WHEN, 32'h00000007);
      rd(`OFS_WHEN, 32'h00000000);
   endtask
   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      t_defaults();
      t_auto();
      t_wait();
      t_immediate();
      setup(4'h9, `WHEN_ENTERED, 15'h0003, 24'h000002, 24'h000003);
      pulse_run('{6, 6, 6, 6}, 4, 3);
      rd(`OFS_STATUS, 32'h00030002);
      setup(4'h9, `WHEN_EXITED, 15'h0002, 24'h000002, 24'h000003);
      pulse_run('{6, 6, 6, 6}, 3, 2);
      setup(4'h1, `WHEN_LONGER, 15'h0003, 24'h00000A, 24'h00000B);
      pulse_run('{8, 25, 6, 6}, 4, 4);
      setup(4'h1, `WHEN_SHORTER, 15'h0001, 24'h00000A, 24'h00000B);
      pulse_run('{25, 30, 6, 6}, 3, 3);
      setup(4'h1, `WHEN_RANGE, 15'h0001, 24'h000008, 24'h00000F);
      pulse_run('{25, 5, 14, 6}, 3, 3);
      t_limits();
      give_verdict();
   end
endmodule // tb_top
bind scope_pattern_trigger_unit scope_trigger_assertions #(
   .AUTO_TIMEOUT_CYCLES(AUTO_TIMEOUT_CYCLES)) chk (.clock(clock), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .chAbove(chAbove),
   .trigger(trigger), .autoTrigger(autoTrigger), .acquireDone(acquireDone),
   .waitingForTrigger(waitingForTrigger));
